// ===== common/i2ce_defs.svh
// Constants of the two-wire EEPROM slave front end
// Overview of operation
// - Device is slave only; master clocks everything.
// - Start is SDA fall, SCL high; not while busy.
// - Stop is SDA rise, SCL high; ends communication.
// - Stop after write data launches write cycle; code launches it only if the last data byte was acked.
// - Stop after unacknowledged read byte gives standby.
// - Transmitter releases SDA; receiver acks ninth pulse.
// - Sample SDA on SCL rise; master changes low.
// - Upper four select bits must match type.
// - Bits b3,b2 match high and low straps.
// - Four devices share bus by strap codes.
// - Select bit zero: one read, zero write.
// - Match acks ninth bit; mismatch gives standby.
// - Write protect high blocks every array change.
// - Protected: ack select, address; no data ack.
// - Byte and page writes, up to 128 bytes; code acks data bytes only while its 16-entry write buffer has room.
// - Sequential reads auto-increment address each byte.
// - During reset nothing responds on the bus.
// - Ignore bus until power-up delay has elapsed.
// - Select bit b1 is top address bit.
// - Write select then two acknowledged address bytes.
// - Random read: dummy write, repeated start, read.
// - Current read outputs counter byte, then increments.
`ifndef I2CE_DEFS_SVH
`define I2CE_DEFS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define I2CE_CLK_PERIOD_PS 5000
`define I2CE_POWER_UP_DELAY_NS 10000
`define I2CE_POWER_UP_CYCLES \
  ((`I2CE_POWER_UP_DELAY_NS * 1000 + `I2CE_CLK_PERIOD_PS - 1) / `I2CE_CLK_PERIOD_PS)

// ----------------------------------------------------------------------------
// Select byte fields and byte framing
// ----------------------------------------------------------------------------
`define I2CE_SEL_TYPE_MSB 7
`define I2CE_SEL_TYPE_LSB 4
`define I2CE_SEL_STRAP_HIGH 3
`define I2CE_SEL_STRAP_LOW 2
`define I2CE_SEL_TOP_ADDR 1
`define I2CE_SEL_DIR 0
`define I2CE_DIR_READ 1'b1
`define I2CE_BITS_ACK 4'h8
`define I2CE_BITS_DONE 4'h9
`define I2CE_PAGE_BITS 7
`define I2CE_FIFO_DEPTH 16

`endif

// ===== common/i2ce_pkg.sv
// Types of the two-wire EEPROM slave front end
package i2ce_pkg;

  typedef enum logic [2:0] {
    I2CE_IDLE = 3'h0,
    I2CE_DEVSEL = 3'h1,
    I2CE_ADDR_HI = 3'h2,
    I2CE_ADDR_LO = 3'h3,
    I2CE_WDATA = 3'h4,
    I2CE_RDATA = 3'h5
  } i2ce_state_t;

  typedef struct packed {
    logic [16:0] addr;
    logic [7:0] data;
  } i2ce_wr_t;

endpackage

// ===== hdl/i2ce_front_end.sv
// Two-wire EEPROM slave front end with its write-data FIFO
`timescale 1ns/10ps
`include "i2ce_defs.svh"

// ----------------------------------------------------------------------------
// Write-data FIFO
// ----------------------------------------------------------------------------
module i2ce_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;

  assign in_ready = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign push = clk_en && in_valid && in_ready;
  assign pop = clk_en && out_valid && out_ready;
  assign next_wr_ptr = wr_ptr + {{AW{1'b0}}, push};
  assign next_rd_ptr = rd_ptr + {{AW{1'b0}}, pop};

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Registered head
  // --------------------------------------------------------------------------
  // Head flag and word are flops, so the array side never sees pointer glitches
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
    end else if (clk_en) begin
      out_valid <= (next_wr_ptr != next_rd_ptr);
    end
  end

  // Bypass when the slot that becomes the head is written in this same cycle
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      if (push && (next_rd_ptr[AW-1:0] == wr_ptr[AW-1:0])) begin
        out_data <= in_data;
      end else begin
        out_data <= mem[next_rd_ptr[AW-1:0]];
      end
    end
  end
endmodule // i2ce_fifo

// ----------------------------------------------------------------------------
// Slave front end
// ----------------------------------------------------------------------------
module i2ce_front_end #(
  // Type identifier value is arbitrary
  parameter logic [3:0] DEV_TYPE_ID = 4'h6
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Straps and protection
  input wire logic chip_sel_strap_low,
  input wire logic chip_sel_strap_high,
  input wire logic write_protect_in,
  // Array write side
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output i2ce_pkg::i2ce_wr_t mem_wr_data,
  output logic wr_cycle_go,
  input wire logic wr_busy_in,
  // Array read side
  output logic [16:0] rd_addr,
  input wire logic [7:0] rd_data,
  // Status
  output logic dev_ready
);
  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic scl_d;
  logic sda_d;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic strap_hi_s;
  logic strap_lo_s;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= 5'h03;
      pin_sync <= 5'h03;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (clk_en) begin
      pin_meta <= {chip_sel_strap_low, chip_sel_strap_high, write_protect_in, sda_in, scl_in};
      pin_sync <= pin_meta;
      scl_d <= pin_sync[0];
      sda_d <= pin_sync[1];
    end
  end

  assign scl_s = pin_sync[0];
  assign sda_s = pin_sync[1];
  assign wp_s = pin_sync[2];
  assign strap_hi_s = pin_sync[3];
  assign strap_lo_s = pin_sync[4];

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det = scl_s && scl_d && !sda_d && sda_s;

  // --------------------------------------------------------------------------
  // Power-up delay
  // --------------------------------------------------------------------------
  localparam int PU_CYCLES = `I2CE_POWER_UP_CYCLES;
  logic [11:0] pu_cnt;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pu_cnt <= '0;
      dev_ready <= 1'b0;
    end else if (clk_en && !dev_ready) begin
      pu_cnt <= pu_cnt + 12'h001;
      dev_ready <= (pu_cnt == 12'(PU_CYCLES - 1));
    end
  end

  // --------------------------------------------------------------------------
  // Write-data buffer
  // --------------------------------------------------------------------------
  logic push_valid;
  logic push_ready;
  i2ce_pkg::i2ce_wr_t push_data;

  i2ce_fifo #(
    .WIDTH($bits(i2ce_pkg::i2ce_wr_t)),
    .DEPTH(`I2CE_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(mem_wr_valid),
    .out_ready(mem_wr_ready),
    .out_data(mem_wr_data)
  );

  // Busy until the array has drained and finished its write cycle
  logic busy;
  assign busy = wr_busy_in || mem_wr_valid;

  // --------------------------------------------------------------------------
  // Protocol engine
  // --------------------------------------------------------------------------
  i2ce_pkg::i2ce_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic read_dir;
  logic master_ack;
  logic wr_pending;
  logic [16:0] addr;
  logic sel_match;
  logic data_ack;

  assign sel_match = (rx_shift[`I2CE_SEL_TYPE_MSB:`I2CE_SEL_TYPE_LSB] == DEV_TYPE_ID)
    && (rx_shift[`I2CE_SEL_STRAP_HIGH] == strap_hi_s)
    && (rx_shift[`I2CE_SEL_STRAP_LOW] == strap_lo_s)
    && !busy;
  // A full buffer also refuses the byte, so no data is lost silently
  assign data_ack = !wp_s && push_ready;

  assign rd_addr = addr;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= i2ce_pkg::I2CE_IDLE;
      bit_cnt <= 4'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      read_dir <= 1'b0;
      master_ack <= 1'b0;
      wr_pending <= 1'b0;
      addr <= 17'h00000;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      push_valid <= 1'b0;
      push_data <= '0;
      wr_cycle_go <= 1'b0;
    end else if (clk_en) begin
      push_valid <= 1'b0;
      wr_cycle_go <= 1'b0;
      if (stop_det) begin
        // The Stop's own SCL rise has already been counted as the first slot of the next byte
        if (state == i2ce_pkg::I2CE_WDATA && bit_cnt == 4'h1 && wr_pending) begin
          wr_cycle_go <= 1'b1;
        end
        state <= i2ce_pkg::I2CE_IDLE;
        wr_pending <= 1'b0;
        sda_oe <= 1'b0;
      end else if (start_det && dev_ready && !busy) begin
        state <= i2ce_pkg::I2CE_DEVSEL;
        bit_cnt <= 4'h0;
        wr_pending <= 1'b0;
        sda_oe <= 1'b0;
      end else if (state != i2ce_pkg::I2CE_IDLE && scl_rise) begin
        if (bit_cnt < `I2CE_BITS_ACK) begin
          rx_shift <= {rx_shift[6:0], sda_s};
        end else begin
          master_ack <= !sda_s;
        end
        bit_cnt <= bit_cnt + 4'h1;
      end else if (state != i2ce_pkg::I2CE_IDLE && scl_fall) begin
        if (bit_cnt == `I2CE_BITS_ACK) begin
          // Ninth clock: receiver answers, transmitter lets go
          sda_oe <= 1'b0;
          case (state)
            i2ce_pkg::I2CE_DEVSEL: begin
              if (sel_match) begin
                sda_oe <= 1'b1;
                read_dir <= (rx_shift[`I2CE_SEL_DIR] == `I2CE_DIR_READ);
                if (rx_shift[`I2CE_SEL_DIR] != `I2CE_DIR_READ) begin
                  addr[16] <= rx_shift[`I2CE_SEL_TOP_ADDR];
                end
              end else begin
                state <= i2ce_pkg::I2CE_IDLE;
              end
            end
            i2ce_pkg::I2CE_ADDR_HI: begin
              sda_oe <= 1'b1;
              addr[15:8] <= rx_shift;
            end
            i2ce_pkg::I2CE_ADDR_LO: begin
              sda_oe <= 1'b1;
              addr[7:0] <= rx_shift;
            end
            i2ce_pkg::I2CE_WDATA: begin
              if (data_ack) begin
                sda_oe <= 1'b1;
                push_valid <= 1'b1;
                push_data <= '{addr: addr, data: rx_shift};
                // Page roll-over: only the low address bits advance
                addr[`I2CE_PAGE_BITS-1:0] <= addr[`I2CE_PAGE_BITS-1:0] + 7'h01;
                wr_pending <= 1'b1;
              end else begin
                wr_pending <= 1'b0;
              end
            end
            default: begin
              sda_oe <= 1'b0;
            end
          endcase
        end else if (bit_cnt == `I2CE_BITS_DONE) begin
          bit_cnt <= 4'h0;
          sda_oe <= 1'b0;
          case (state)
            i2ce_pkg::I2CE_DEVSEL: begin
              if (read_dir) begin
                state <= i2ce_pkg::I2CE_RDATA;
                sda_oe <= !rd_data[7];
                tx_shift <= {rd_data[6:0], 1'b0};
                addr <= addr + 17'h00001;
              end else begin
                state <= i2ce_pkg::I2CE_ADDR_HI;
              end
            end
            i2ce_pkg::I2CE_ADDR_HI: begin
              state <= i2ce_pkg::I2CE_ADDR_LO;
            end
            i2ce_pkg::I2CE_ADDR_LO: begin
              state <= i2ce_pkg::I2CE_WDATA;
            end
            i2ce_pkg::I2CE_WDATA: begin
              state <= i2ce_pkg::I2CE_WDATA;
            end
            i2ce_pkg::I2CE_RDATA: begin
              if (master_ack) begin
                sda_oe <= !rd_data[7];
                tx_shift <= {rd_data[6:0], 1'b0};
                addr <= addr + 17'h00001;
              end else begin
                state <= i2ce_pkg::I2CE_IDLE;
              end
            end
            default: begin
              state <= i2ce_pkg::I2CE_IDLE;
            end
          endcase
        end else if (state == i2ce_pkg::I2CE_RDATA) begin
          sda_oe <= !tx_shift[7];
          tx_shift <= {tx_shift[6:0], 1'b0};
        end
      end
    end
  end
endmodule // i2ce_front_end

// ===== dv/i2ce_chk.sv
// Assertion checker for the EEPROM slave front end
`timescale 1ns/10ps
`include "i2ce_defs.svh"
module i2ce_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Control and array side
  input wire logic write_protect_in,
  input wire logic mem_wr_valid,
  input wire logic mem_wr_ready,
  input i2ce_pkg::i2ce_wr_t mem_wr_data,
  input wire logic wr_cycle_go,
  input wire logic wr_busy_in,
  input wire logic dev_ready
);
  // --------------------
  // Properties
  // --------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  localparam int PU = `I2CE_POWER_UP_CYCLES;
  logic [11:0] up_cnt;
  // Counts every rising clock edge until ready
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      up_cnt <= 12'h000;
    end else if (!dev_ready) begin
      up_cnt <= up_cnt + 12'h001;
    end
  end
  sequence stop_s;
    scl_in && $rose(sda_in);
  endsequence
  open_drain_a: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  early_quiet_a: assert property (!dev_ready |-> !sda_oe)
    else $error("ack before ready");
  power_up_a: assert property ($rose(dev_ready) |-> up_cnt >= PU - 1 && up_cnt <= PU + 1)
    else $error("power-up delay wrong");
  ready_hold_a: assert property (dev_ready |=> dev_ready)
    else $error("ready dropped");
  busy_quiet_a: assert property (wr_busy_in && !sda_oe |=> !sda_oe)
    else $error("ack while busy");
  oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda changed with scl high");
  go_pulse_a: assert property (wr_cycle_go |=> !wr_cycle_go)
    else $error("write go too long");
  go_stop_a: assert property (wr_cycle_go |-> scl_in && sda_in && !$past(sda_in, 6))
    else $error("write go without stop");
  wp_no_push_a: assert property (write_protect_in && !mem_wr_valid |=> !mem_wr_valid)
    else $error("push while protected");
  fifo_hold_a: assert property (mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr_data))
    else $error("fifo head lost");
  stop_idle_a: assert property (stop_s |-> ##3 !sda_oe [*8])
    else $error("drive after stop");
endmodule // i2ce_chk

// ===== dv/i2ce_master.sv
// Two-wire bus master model, 160 ns bit period
`timescale 1ns/10ps
module i2ce_master (
  // Bus lines
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // --------------------
  // Bit and frame timing
  // --------------------
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic put_bit(input logic b);
    #40 sda_low = ~b;
    #40 scl = 1'b1;
    #80 scl = 1'b0;
  endtask
  task automatic get_bit(output logic b);
    #40 sda_low = 1'b0;
    #40 scl = 1'b1;
    #40 b = sda;
    #40 scl = 1'b0;
  endtask
  task automatic start;
    if (!scl) begin
      #40 sda_low = 1'b0;
      #40 scl = 1'b1;
    end
    #40 sda_low = 1'b1;
    #40 scl = 1'b0;
  endtask
  task automatic stop;
    #40 sda_low = 1'b1;
    #40 scl = 1'b1;
    #40 sda_low = 1'b0;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask
  task automatic recv(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(~ack);
  endtask
endmodule // i2ce_master

// ===== dv/testbench.sv
// Self-checking bench of the EEPROM slave front end
`timescale 1ns/10ps
module testbench;
  // --------------------
  // Harness
  // --------------------
  logic clk_sys, reset_n, sda_oe, chip_sel_strap_low, chip_sel_strap_high, write_protect_in;
  logic mem_wr_valid, mem_wr_ready, wr_cycle_go, wr_busy_in, dev_ready, scl, m_low;
  logic [16:0] rd_addr;
  logic [16:0] addr_model;
  i2ce_pkg::i2ce_wr_t mem_wr_data;
  i2ce_pkg::i2ce_wr_t popq[$];
  int failures, total_checks, go_cnt;
  wire logic sda_w = ~(m_low | sda_oe);
  i2ce_front_end #(.DEV_TYPE_ID(4'h6)) i_i2ce_front_end (.clk_sys(clk_sys), .reset_n(reset_n),
    .clk_en(1'b1), .scl_in(scl), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe),
    .chip_sel_strap_low(chip_sel_strap_low), .chip_sel_strap_high(chip_sel_strap_high),
    .write_protect_in(write_protect_in), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr_data(mem_wr_data), .wr_cycle_go(wr_cycle_go),
    .wr_busy_in(wr_busy_in), .rd_addr(rd_addr), .rd_data(rd_addr[7:0] ^ 8'h5a),
    .dev_ready(dev_ready));
  i2ce_master i_i2ce_master (.scl(scl), .sda_low(m_low), .sda(sda_w));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (wr_cycle_go) go_cnt++;
    if (mem_wr_valid && mem_wr_ready) popq.push_back(mem_wr_data);
  end
  task automatic chk_ack(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t ack got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [24:0] got, input logic [24:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t value got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic sync;
    @(posedge clk_sys);
    #1;
  endtask
  // Select, then n read bytes when acked, last one not acked
  task automatic probe(input logic [7:0] sel, input logic exp, input int n);
    logic a;
    logic [7:0] d;
    i_i2ce_master.start();
    i_i2ce_master.send(sel, a);
    chk_ack(a, exp);
    for (int i = 0; i < n && a; i++) begin
      i_i2ce_master.recv(i < n - 1, d);
      chk_val(25'(d), 25'(addr_model[7:0] ^ 8'h5a));
      addr_model++;
    end
    i_i2ce_master.stop();
  endtask
  task automatic wr(input logic [7:0] sel, input logic [15:0] a, input int n, input int acks,
                    input logic fin);
    logic k;
    i_i2ce_master.start();
    i_i2ce_master.send(sel, k);
    chk_ack(k, 1'b1);
    for (int i = 0; i < 2; i++) begin
      i_i2ce_master.send(a[15 - 8 * i -: 8], k);
      chk_ack(k, 1'b1);
    end
    for (int i = 0; i < n; i++) begin
      i_i2ce_master.send(8'(i + 8'h30), k);
      chk_ack(k, i < acks);
    end
    if (fin) i_i2ce_master.stop();
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    summarize;
  end
  initial begin
    {reset_n, chip_sel_strap_high, chip_sel_strap_low} = 3'b010;
    {write_protect_in, mem_wr_ready, wr_busy_in} = 3'b000;
    {failures, total_checks, go_cnt} = '0;
    addr_model = 17'h00000;
    repeat (2) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    probe(8'h69, 1'b0, 1);
    for (int w = 0; w < 3000 && !dev_ready; w++) sync;
    chk_ack(dev_ready, 1'b1);
    $display("test power-up done");
    probe(8'h79, 1'b0, 1);
    for (int k = 0; k < 4; k++) begin
      sync;
      {chip_sel_strap_high, chip_sel_strap_low} = 2'(k);
      probe({4'h6, 2'(k ^ 1), 2'b01}, 1'b0, 1);
      probe({4'h6, 2'(k), 2'b01}, 1'b1, 1);
    end
    sync;
    {chip_sel_strap_high, chip_sel_strap_low} = 2'b10;
    $display("test select done");
    wr(8'h6a, 16'h127f, 17, 16, 1'b1);
    repeat (10) sync;
    chk_val(25'(go_cnt), 25'd0);
    probe(8'h69, 1'b0, 1);
    sync;
    mem_wr_ready = 1'b1;
    repeat (20) sync;
    chk_val(25'(popq.size()), 25'd16);
    chk_val(popq[0], {17'h1127f, 8'h30});
    chk_val(popq[1], {17'h11200, 8'h31});
    chk_val(popq[15], {17'h1120e, 8'h3f});
    wr(8'h68, 16'h0040, 1, 1, 1'b1);
    repeat (10) sync;
    chk_val(25'(go_cnt), 25'd1);
    chk_val(popq[16], {17'h00040, 8'h30});
    wr_busy_in = 1'b1;
    probe(8'h69, 1'b0, 1);
    sync;
    {wr_busy_in, write_protect_in} = 2'b01;
    $display("test write done");
    wr(8'h68, 16'h0100, 2, 0, 1'b1);
    repeat (10) sync;
    write_protect_in = 1'b0;
    chk_val(25'(popq.size()), 25'd17);
    chk_val(25'(go_cnt), 25'd1);
    wr(8'h68, 16'h01ff, 0, 0, 1'b0);
    addr_model = 17'h001ff;
    probe(8'h69, 1'b1, 3);
    probe(8'h69, 1'b1, 1);
    chk_val(25'(rd_addr), 25'(addr_model));
    $display("test read done");
    summarize;
  end
endmodule // testbench
bind i2ce_front_end i2ce_chk i_i2ce_chk (.clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .write_protect_in(write_protect_in),
  .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_data(mem_wr_data),
  .wr_cycle_go(wr_cycle_go), .wr_busy_in(wr_busy_in), .dev_ready(dev_ready));
